/* File: rtl/ocf_fault_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ocf_cfg.svh"
module ocf_fault_ctrl
	import ocf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Command port from the bus decoder
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic [7:0] phase_sel,
	input wire logic nvm_restore,
	input wire logic clear_faults,
	// Read answer
	output logic [15:0] rd_data,
	output logic rd_valid,
	// Converter side
	input wire logic on_cmd,
	input wire logic start_ok,
	input wire logic [15:0] ton_rise_ticks,
	input wire logic [7:0] temp_c,
	input wire logic pwm_clk_pin,
	input wire logic oc_fault_pin,
	input wire logic [`NPH-1:0] ocw_pin,
	output logic conv_enable,
	output logic [`NPH-1:0][4:0] ocw_code,
	output logic ot_fault,
	// Status
	output logic stat_iout_oc,
	output logic stat_nota,
	output logic stat_iout,
	output logic stat_ocf,
	output logic stat_ocw,
	output logic [`NPH-1:0] stat_ocw_ph,
	output logic stat_cml,
	output logic alert_n
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Linear to fixed point; bit 16 flags negative or overflow
	function automatic logic [16:0] lin_conv(input logic [15:0] v,
		input logic signed [5:0] frac, input logic [1:0] md);
		logic signed [5:0] s;
		logic [31:0] acc;
		logic [31:0] rem;
		logic [4:0] sh;
		s = $signed({v[15], v[15:11]}) + frac;
		acc = {21'h000000, v[10:0]};
		rem = 32'h0;
		sh = 5'h0;
		if (s > 6'sh05) begin
			acc = 32'hffffffff;
		end else if (s >= 6'sh00) begin
			acc = acc << s[2:0];
		end else begin
			sh = (s < -6'sh0c) ? 5'h0c : 5'(-s);
			rem = acc & ((32'h1 << sh) - 32'h1);
			acc = acc >> sh;
			if (md == `MD_CEIL && rem != 32'h0) begin
				acc = acc + 32'h1;
			end else if (md == `MD_NEAR && rem[sh - 5'h1]) begin
				acc = acc + 32'h1;
			end
		end
		return {v[10] | (acc > 32'h0000ffff), acc[15:0]};
	endfunction : lin_conv

	// quarter amps to 2 A step code, rounded up
	function automatic logic [4:0] hw_code(input logic [15:0] q);
		logic [15:0] t;
		t = 16'h0;
		// below 8 A applies the 8 A step
		if (q > `OCW_MIN_Q) begin
			t = (q - `OCW_MIN_Q + `OCW_STEP_Q - 16'h1) / `OCW_STEP_Q;
		end
		if (t > `OCW_MAX_CODE) begin
			t = `OCW_MAX_CODE;
		end
		return t[4:0];
	endfunction : hw_code

	function automatic logic [19:0] shut_dly(input logic [2:0] c);
		if (c < `DLY_C_MID) begin
			return `DLY_SHORT;
		end else if (c < `DLY_C_LONG) begin
			return `DLY_MID;
		end
		return `DLY_LONG;
	endfunction : shut_dly

	// hiccup multiple of the rise time
	function automatic logic [2:0] hic_mult(input logic [2:0] c);
		return (c < `DLY_C_MID) ? 3'h1 : c;
	endfunction : hic_mult

	function automatic ocf_state_t shut_to(input logic [2:0] rt,
		input logic [2:0] tr);
		if (rt == 3'h0) begin
			return ST_LATCH;
		end else if (rt == `RETRY_FOREVER || tr < rt) begin
			return ST_HICCUP;
		end
		return ST_LATCH;
	endfunction : shut_to

	// ----------------------------------------
	// State
	// ----------------------------------------
	ocf_regs_t r;
	ocf_regs_t n;
	logic tick;
	logic [1:0] act;
	logic [2:0] retry;
	logic [2:0] dsel;
	logic [19:0] hic;
	logic [16:0] wq;
	logic [16:0] wd;
	logic [16:0] otd;
	logic [16:0] nq;
	logic [16:0] q0;

	assign act = r.ocr[7:6];
	assign retry = r.ocr[5:3];
	assign dsel = r.ocr[2:0];
	assign tick = r.pw_s & ~r.pw_d;
	// Widen before the product so long rise times do not wrap
	assign hic = 20'(hic_mult(dsel)) * 20'(ton_rise_ticks);

	always_comb begin
		n = r;
		wq = lin_conv(cmd_wdata, `Q_FRAC, `MD_CEIL);
		wd = lin_conv(cmd_wdata, `DEG_FRAC, `MD_CEIL);
		otd = lin_conv(r.otl, `DEG_FRAC, `MD_CEIL);
		q0 = lin_conv(r.ocw[0], `Q_FRAC, `MD_CEIL);
		nq = 17'h0;
		// Pins cross into the clock through two stages
		n.oc_m = oc_fault_pin;
		n.oc_s = r.oc_m;
		n.ow_m = ocw_pin;
		n.ow_s = r.ow_m;
		n.pw_m = pwm_clk_pin;
		n.pw_s = r.pw_m;
		n.pw_d = r.pw_s;
		n.rd_v = 1'b0;

		// ----------------------------------------
		// Status; clear goes first so a new event wins
		// ----------------------------------------
		if (clear_faults) begin
			n.s_oc = 1'b0;
			n.s_nota = 1'b0;
			n.s_iout = 1'b0;
			n.s_ocf = 1'b0;
			n.s_ocw = 1'b0;
			n.s_ph = '0;
			n.s_cml = 1'b0;
		end
		if (r.en && r.oc_s) begin
			n.s_oc = 1'b1;
			n.s_iout = 1'b1;
			n.s_ocf = 1'b1;
		end
		if (|r.ow_s) begin
			n.s_nota = 1'b1;
			n.s_iout = 1'b1;
			n.s_ocw = 1'b1;
			n.s_ph = r.s_ph | r.ow_s;
		end

		// ----------------------------------------
		// Commands
		// ----------------------------------------
		if (cmd_valid) begin
			n.rd_v = ~cmd_write;
			n.rd = 16'h0;
			case (cmd_code)
				`CMD_OC_RESP: begin
					if (cmd_write) begin
						n.ocr = (r.ocr & ~`OCR_WR_MASK) |
							(cmd_wdata[7:0] & `OCR_WR_MASK);
					end
					n.rd = {8'h00, r.ocr};
				end
				`CMD_OCW_LIM: begin
					if (cmd_write && phase_sel == `PHASE_ALL) begin
						if (wq[16] || wq[15:0] > `OCW_MAX_Q * `NPH) begin
							n.s_cml = 1'b1;
						end else begin
							for (int i = 0; i < `NPH; i++) begin
								n.ocw[i] = {`EXP_Q,
									11'((wq[15:0] + 16'h1) >> 1)};
							end
						end
					end else if (cmd_write) begin
						if (wq[16] || wq[15:0] > `OCW_MAX_Q) begin
							n.s_cml = 1'b1;
						end else begin
							n.ocw[phase_sel[0]] = cmd_wdata;
						end
					end
					if (phase_sel == `PHASE_ALL) begin
						n.rd = {`EXP_Q, 11'(q0[15:0] << 1)};
					end else begin
						n.rd = r.ocw[phase_sel[0]];
					end
				end
				`CMD_OT_LIM: begin
					if (cmd_write) begin
						// negative or beyond the disable value
						if (wd[16] || wd[15:0] > `OT_DISABLE) begin
							n.s_cml = 1'b1;
						end else begin
							n.otl = cmd_wdata;
						end
					end
					n.rd = r.otl;
				end
				default: begin
					n.rd = 16'h0;
				end
			endcase
		end

		// ----------------------------------------
		// Restore to stored resolution
		// ----------------------------------------
		if (nvm_restore) begin
			for (int i = 0; i < `NPH; i++) begin
				nq = lin_conv(r.ocw[i], `Q_FRAC, `MD_NEAR);
				if (nq[16] || nq[15:0] > `OCW_MAX_Q) begin
					nq = {1'b0, `OCW_MAX_Q};
				end
				n.ocw[i] = {`EXP_Q, nq[10:0]};
			end
			nq = lin_conv(r.otl, `DEG_FRAC, `MD_NEAR);
			if (nq[16] || nq[15:0] > `OT_NVM_MAX) begin
				nq = {1'b0, `OT_NVM_MAX};
			end
			n.otl = {`EXP_DEG, nq[10:0]};
		end

		// ----------------------------------------
		// Thresholds
		// ----------------------------------------
		for (int i = 0; i < `NPH; i++) begin
			n.code[i] = hw_code(
				16'(lin_conv(r.ocw[i], `Q_FRAC, `MD_CEIL)));
		end
		// programmable limit only; die shutdown is elsewhere
		n.ot_flt = ~otd[16] && otd[15:0] != `OT_DISABLE &&
			{8'h00, temp_c} >= otd[15:0];

		// ----------------------------------------
		// Fault response
		// ----------------------------------------
		case (r.st)
			ST_IDLE: begin
				if (on_cmd) begin
					n.st = ST_START;
				end
			end
			ST_START, ST_RUN: begin
				if (r.st == ST_START && start_ok) begin
					n.st = ST_RUN;
					// a good start forgets earlier tries
					n.tries = 3'h0;
				end
				// 10b waits, 11b acts now, else keep running
				if (r.oc_s && act == `ACT_NOW) begin
					n.st = shut_to(retry, r.tries);
					n.cnt = hic;
				end else if (r.oc_s && act == `ACT_DELAY) begin
					n.st = ST_DELAY;
					n.cnt = shut_dly(dsel);
				end
			end
			ST_DELAY: begin
				// Fault gone before the delay ran out
				if (!r.oc_s) begin
					n.st = ST_RUN;
				end else if (tick && r.cnt <= 20'h1) begin
					n.st = shut_to(retry, r.tries);
					n.cnt = hic;
				end else if (tick) begin
					n.cnt = r.cnt - 20'h1;
				end
			end
			ST_HICCUP: begin
				// one hiccup period then a new try
				if (tick && r.cnt == 20'h0) begin
					n.st = ST_START;
					if (r.tries != `RETRY_FOREVER) begin
						n.tries = r.tries + 3'h1;
					end
				end else if (tick) begin
					n.cnt = r.cnt - 20'h1;
				end
			end
			ST_LATCH: begin
				n.st = ST_LATCH;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
		if (!on_cmd) begin
			n.st = ST_IDLE;
			n.tries = 3'h0;
		end
		n.en = n.st == ST_START || n.st == ST_RUN || n.st == ST_DELAY;
		n.alert_n = ~(n.s_oc | n.s_nota | n.s_iout | n.s_ocf |
			n.s_ocw | n.s_cml);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.ocr <= `OCR_RESET;
			r.ocw <= {`NPH{`OCW_RESET}};
			r.otl <= `OT_RESET;
			r.alert_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign rd_data = r.rd;
	assign rd_valid = r.rd_v;
	assign conv_enable = r.en;
	assign ocw_code = r.code;
	assign ot_fault = r.ot_flt;
	assign stat_iout_oc = r.s_oc;
	assign stat_nota = r.s_nota;
	assign stat_iout = r.s_iout;
	assign stat_ocf = r.s_ocf;
	assign stat_ocw = r.s_ocw;
	assign stat_ocw_ph = r.s_ph;
	assign stat_cml = r.s_cml;
	assign alert_n = r.alert_n;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_run_fault;
		r.st == ST_RUN && r.oc_s && on_cmd;
	endsequence
	sequence s_hic_end;
		r.st == ST_HICCUP && tick && r.cnt == 20'h0 && on_cmd;
	endsequence

	property p_oc_flags;
		r.en && r.oc_s && !clear_faults |=>
			r.s_ocf && r.s_oc && r.s_iout && !r.alert_n;
	endproperty
	a_oc_flags: assert property (p_oc_flags)
		else $error("fault flags not set");
	property p_act_now;
		s_run_fault ##0 act == `ACT_NOW |=> !r.en;
	endproperty
	a_act_now: assert property (p_act_now)
		else $error("immediate shutdown missed");
	property p_no_retry;
		s_run_fault ##0 act == `ACT_NOW && retry == 3'h0 |=>
			r.st == ST_LATCH;
	endproperty
	a_no_retry: assert property (p_no_retry)
		else $error("zero retry did not latch");
	property p_tries;
		r.st == ST_START && retry != `RETRY_FOREVER |->
			r.tries <= retry || r.tries == 3'h0;
	endproperty
	a_tries: assert property (p_tries)
		else $error("too many restart tries");
	property p_forever;
		s_hic_end ##0 retry == `RETRY_FOREVER |=> r.st == ST_START;
	endproperty
	a_forever: assert property (p_forever)
		else $error("endless retry stopped");
	property p_dly_mid;
		s_run_fault ##0 act == `ACT_DELAY && dsel >= `DLY_C_MID &&
			dsel < `DLY_C_LONG |=> r.st == ST_DELAY && r.cnt == `DLY_MID;
	endproperty
	a_dly_mid: assert property (p_dly_mid)
		else $error("wrong shutdown delay");
	property p_dly_short;
		s_run_fault ##0 act == `ACT_DELAY && dsel < `DLY_C_MID |=>
			r.st == ST_DELAY && r.cnt == `DLY_SHORT;
	endproperty
	a_dly_short: assert property (p_dly_short)
		else $error("wrong short shutdown delay");
	property p_invalid;
		cmd_valid && cmd_write && cmd_code == `CMD_OCW_LIM &&
			cmd_wdata[10] |=> r.s_cml ##1 !r.alert_n;
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("invalid write not flagged");
	property p_ot_off;
		otd[15:0] == `OT_DISABLE |=> !r.ot_flt;
	endproperty
	a_ot_off: assert property (p_ot_off)
		else $error("disabled limit still faults");
	property p_off_clear;
		!on_cmd |=> r.tries == 3'h0 && r.st == ST_IDLE;
	endproperty
	a_off_clear: assert property (p_off_clear)
		else $error("tries not cleared when off");

endmodule : ocf_fault_ctrl
`default_nettype wire

/* File: rtl/ocf_cfg.svh */
`ifndef OCF_CFG_SVH
`define OCF_CFG_SVH
`define NPH 2
`define CMD_OC_RESP 8'h47
`define CMD_OCW_LIM 8'h4a
`define CMD_OT_LIM 8'h4f
`define PHASE_ALL 8'hff
`define OCR_RESET 8'h80
`define OCR_WR_MASK 8'hf8
`define OCW_RESET 16'hf0a0
`define OT_RESET 16'h007d
`define EXP_Q 5'h1e
`define EXP_DEG 5'h00
`define Q_FRAC 6'sh02
`define DEG_FRAC 6'sh00
`define MD_CEIL 2'h1
`define MD_NEAR 2'h2
`define ACT_DELAY 2'h2
`define ACT_NOW 2'h3
`define RETRY_FOREVER 3'h7
`define DLY_C_MID 3'h2
`define DLY_C_LONG 3'h5
`define DLY_SHORT 20'h00001
`define DLY_MID 20'h00003
`define DLY_LONG 20'h00007
`define OCW_MIN_Q 16'h0020
`define OCW_STEP_Q 16'h0008
`define OCW_MAX_Q 16'h00f8
`define OCW_MAX_CODE 16'h001b
`define OT_DISABLE 16'h00ff
`define OT_NVM_MAX 16'h00a0
`endif

/* File: rtl/ocf_pkg.sv */
`include "ocf_cfg.svh"
package ocf_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_RUN = 3'b010,
		ST_DELAY = 3'b011,
		ST_HICCUP = 3'b100,
		ST_LATCH = 3'b101
	} ocf_state_t;

	typedef struct packed {
		ocf_state_t st;
		logic [19:0] cnt;
		logic [2:0] tries;
		logic en;
		logic [7:0] ocr;
		logic [`NPH-1:0][15:0] ocw;
		logic [15:0] otl;
		logic [`NPH-1:0][4:0] code;
		logic ot_flt;
		logic oc_m;
		logic oc_s;
		logic [`NPH-1:0] ow_m;
		logic [`NPH-1:0] ow_s;
		logic pw_m;
		logic pw_s;
		logic pw_d;
		logic s_oc;
		logic s_nota;
		logic s_iout;
		logic s_ocf;
		logic s_ocw;
		logic [`NPH-1:0] s_ph;
		logic s_cml;
		logic alert_n;
		logic [15:0] rd;
		logic rd_v;
	} ocf_regs_t;
endpackage : ocf_pkg

/* File: tb/ocf_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ocf_host_model (
	// Clock
	input wire logic clk,
	// Command side
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	output logic [7:0] phase_sel,
	// Answer side
	input wire logic [15:0] rd_data,
	input wire logic rd_valid
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
		phase_sel = 8'hff;
	end

	// ------------------------------------------------------------
	// One management transfer
	// ------------------------------------------------------------
	// byte or word, whole in one command
	task automatic xfer(input logic wr, input logic [7:0] code,
		input logic [15:0] data, input logic [7:0] ph,
		output logic [15:0] rdata, output logic ok);
		int i;
		rdata = 16'h0000;
		ok = wr;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_code = code;
		cmd_wdata = data;
		phase_sel = ph;
		@(negedge clk);
		cmd_valid = 1'b0;
		// Stale data inverted so a late sample cannot pass
		cmd_wdata = ~data;
		// Answer stands for the cycle after the command edge
		for (i = 0; i < 3 && !ok; i++) begin
			if (rd_valid === 1'b1) begin
				rdata = rd_data;
				ok = 1'b1;
			end else begin
				@(negedge clk);
			end
		end
	endtask : xfer
endmodule : ocf_host_model
`default_nettype wire

/* File: tb/test_overcurrent_overtemp_fault_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ocf_cfg.svh"
module test_overcurrent_overtemp_fault_control;
	import ocf_pkg::*;
	logic clk, reset_n, cmd_valid, cmd_write, nvm_restore, clear_faults;
	logic [7:0] cmd_code, phase_sel, temp_c;
	logic [15:0] cmd_wdata, rd_data;
	logic rd_valid, on_cmd, start_ok, oc_fault_pin, conv_enable, ot_fault;
	logic [`NPH-1:0] ocw_pin, stat_ocw_ph;
	logic [`NPH-1:0][4:0] ocw_code;
	logic stat_iout_oc, stat_nota, stat_iout, stat_ocf, stat_ocw, stat_cml;
	logic alert_n;
	logic [2:0] pcnt;
	int miscompares, samples_checked, k, n;
	logic prev;
	logic [15:0] wv [5] = '{16'hf0a4, 16'hf014, 16'hf020, 16'hf022,
		16'hf0f8};
	logic [4:0] wc [5] = '{5'd17, 5'd0, 5'd0, 5'd1, 5'd27};
	logic [7:0] bc [4] = '{8'h4a, 8'h4a, 8'h4f, 8'h4f};
	logic [15:0] bv [4] = '{16'hf0fc, 16'hf1f4, 16'h07ff, 16'h0100};
	logic [7:0] bp [4] = '{8'h00, 8'hff, 8'hff, 8'hff};
	logic [7:0] fr [7] = '{8'hc0, 8'hc8, 8'hd8, 8'h88, 8'h00, 8'h40,
		8'hf8};
	int fn [7] = '{0, 1, 3, 1, 0, 0, 7};
	int fe [7] = '{0, 0, 0, 0, 1, 1, 2};

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial pcnt = 3'h0;
	// Switching clock runs free at an eighth of the core rate
	always @(negedge clk) pcnt <= pcnt + 3'h1;

	ocf_host_model host (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .phase_sel(phase_sel),
		.rd_data(rd_data), .rd_valid(rd_valid));
	ocf_fault_ctrl dut (.clk(clk), .reset_n(reset_n),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.phase_sel(phase_sel), .nvm_restore(nvm_restore),
		.clear_faults(clear_faults), .rd_data(rd_data),
		.rd_valid(rd_valid), .on_cmd(on_cmd), .start_ok(start_ok),
		.ton_rise_ticks(16'h0002), .temp_c(temp_c),
		.pwm_clk_pin(pcnt[2]), .oc_fault_pin(oc_fault_pin),
		.ocw_pin(ocw_pin), .conv_enable(conv_enable),
		.ocw_code(ocw_code), .ot_fault(ot_fault),
		.stat_iout_oc(stat_iout_oc), .stat_nota(stat_nota),
		.stat_iout(stat_iout), .stat_ocf(stat_ocf),
		.stat_ocw(stat_ocw), .stat_ocw_ph(stat_ocw_ph),
		.stat_cml(stat_cml), .alert_n(alert_n));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [15:0] flags();
		return {9'h000, stat_iout_oc, stat_nota, stat_iout, stat_ocf,
			stat_ocw, stat_cml, alert_n};
	endfunction : flags

	task automatic wr(input logic [7:0] c, input logic [15:0] d,
		input logic [7:0] ph);
		logic [15:0] r;
		logic ok;
		host.xfer(1'b1, c, d, ph, r, ok);
	endtask : wr

	task automatic rd_chk(input logic [7:0] c, input logic [7:0] ph,
		input logic [15:0] exp);
		logic [15:0] r;
		logic ok;
		host.xfer(1'b0, c, 16'h0000, ph, r, ok);
		check({15'h0000, ok}, 16'h0001);
		check(r, exp);
	endtask : rd_chk

	task automatic pulse_clear();
		clear_faults = 1'b1;
		@(negedge clk);
		clear_faults = 1'b0;
		repeat (2) @(negedge clk);
	endtask : pulse_clear

	task automatic restore();
		nvm_restore = 1'b1;
		@(negedge clk);
		nvm_restore = 1'b0;
		repeat (3) @(negedge clk);
	endtask : restore

	task automatic wait_en(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && conv_enable !== v; i++) @(negedge clk);
		check({15'h0000, conv_enable}, {15'h0000, v});
	endtask : wait_en

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked,
			miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		$display("BAD at %0t: run did not finish", $time);
		give_verdict();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		nvm_restore = 1'b0;
		clear_faults = 1'b0;
		on_cmd = 1'b0;
		start_ok = 1'b0;
		temp_c = 8'h19;
		oc_fault_pin = 1'b0;
		ocw_pin = 2'b00;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		check(flags(), 16'h0001);
		rd_chk(8'h47, 8'hff, 16'h0080);
		rd_chk(8'h4a, 8'h00, 16'hf0a0);
		rd_chk(8'h4f, 8'hff, 16'h007d);
		// Delay field reads back fixed
		wr(8'h47, 16'h00ff, 8'hff);
		rd_chk(8'h47, 8'hff, 16'h00f8);
		// threshold steps, rounded up, floor at 8 A
		for (k = 0; k < 5; k++) begin
			wr(8'h4a, wv[k], 8'h00);
			repeat (3) @(negedge clk);
			check({11'h000, ocw_code[0]}, {11'h000, wc[k]});
		end
		for (k = 0; k < 4; k++) begin
			wr(bc[k], bv[k], bp[k]);
			@(negedge clk);
			check(flags(), 16'h0002);
			pulse_clear();
		end
		rd_chk(8'h4a, 8'h00, 16'hf0f8);
		wr(8'h4a, 16'hf028, 8'h01);
		repeat (3) @(negedge clk);
		check({6'h00, ocw_code}, {6'h00, 5'd1, 5'd27});
		wr(8'h4a, 16'hf0a0, 8'hff);
		rd_chk(8'h4a, 8'hff, 16'hf0a0);
		repeat (2) @(negedge clk);
		check({6'h00, ocw_code}, {6'h00, 5'd6, 5'd6});
		wr(8'h4a, 16'he291, 8'h00);
		restore();
		rd_chk(8'h4a, 8'h00, 16'hf0a4);
		wr(8'h4f, 16'h00ff, 8'hff);
		temp_c = 8'hff;
		repeat (4) @(negedge clk);
		check({15'h0000, ot_fault}, 16'h0000);
		restore();
		rd_chk(8'h4f, 8'hff, 16'h00a0);
		check({15'h0000, ot_fault}, 16'h0001);
		temp_c = 8'h9f;
		repeat (4) @(negedge clk);
		check({15'h0000, ot_fault}, 16'h0000);
		temp_c = 8'ha0;
		repeat (4) @(negedge clk);
		check({15'h0000, ot_fault}, 16'h0001);
		temp_c = 8'h19;
		pulse_clear();
		on_cmd = 1'b1;
		wait_en(1'b1, 50);
		start_ok = 1'b1;
		@(negedge clk);
		start_ok = 1'b0;
		ocw_pin = 2'b10;
		repeat (6) @(negedge clk);
		check({14'h0000, stat_ocw_ph}, 16'h0002);
		check(flags(), 16'h0034);
		ocw_pin = 2'b00;
		// Let the pin synchroniser drain, else the set beats the clear
		repeat (3) @(negedge clk);
		pulse_clear();
		check(flags(), 16'h0001);
		for (k = 0; k < 7; k++) begin
			wr(8'h47, {8'h00, fr[k]}, 8'hff);
			on_cmd = 1'b0;
			@(negedge clk);
			pulse_clear();
			on_cmd = 1'b1;
			wait_en(1'b1, 50);
			start_ok = 1'b1;
			@(negedge clk);
			start_ok = 1'b0;
			oc_fault_pin = 1'b1;
			n = 0;
			prev = 1'b1;
			repeat (400) begin
				@(negedge clk);
				if (conv_enable === 1'b1 && !prev)
					n++;
				prev = conv_enable;
			end
			if (n > 7)
				n = 7;
			check(16'(n), 16'(fn[k]));
			check(flags() & 16'h0058, 16'h0058);
			if (fe[k] < 2)
				check({15'h0000, conv_enable}, 16'(fe[k]));
			oc_fault_pin = 1'b0;
		end
		on_cmd = 1'b0;
		repeat (4) @(negedge clk);
		check({15'h0000, conv_enable}, 16'h0000);
		give_verdict();
	end
endmodule : test_overcurrent_overtemp_fault_control
`default_nettype wire
